// File: core/sample_control.sv
// sampling, multicast and range-flag control with apb register access
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
module sample_control #(
    parameter int NCH = isc_pkg::NCH,
    parameter bit CURRENT_ONLY = 1'b0,
    parameter int TICK_CYCLES = isc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter
    output logic scan_req,
    input wire logic adc_valid,
    input wire logic [NCH*16-1:0] adc_sample,
    // multicast to the owner
    output logic mcast_valid,
    output logic mcast_fresh,
    output logic [NCH*16-1:0] mcast_data,
    // channel status
    output logic [NCH-1:0] ch_fault,
    // interrupt
    output logic irq
);
    // ========================================================================
    // lookup functions
    function automatic logic [15:0] min_rts_ms(input logic [2:0] notch, input logic fmt_float);
        logic [15:0] v;
        v = 16'h0066;
        if (fmt_float) begin
            v = (notch == isc_pkg::NOTCH_10) ? 16'h0066 : 16'h0019;
        end else begin
            case (notch)
                isc_pkg::NOTCH_10: v = 16'h0066;
                isc_pkg::NOTCH_50: v = 16'h0016;
                isc_pkg::NOTCH_60: v = 16'h0013;
                isc_pkg::NOTCH_100: v = 16'h000C;
                default: v = 16'h000A;
            endcase
        end
        return v;
    endfunction

    function automatic logic [15:0] step_ms(input logic [2:0] notch);
        logic [15:0] v;
        case (notch)
            isc_pkg::NOTCH_10: v = 16'h0190;
            isc_pkg::NOTCH_50: v = 16'h0050;
            isc_pkg::NOTCH_60: v = 16'h0044;
            isc_pkg::NOTCH_100: v = 16'h0028;
            isc_pkg::NOTCH_250: v = 16'h0010;
            default: v = 16'h0004;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] resolution(input logic [2:0] notch);
        logic [7:0] v;
        case (notch)
            isc_pkg::NOTCH_250: v = 8'h0F;
            isc_pkg::NOTCH_1000: v = 8'h0A;
            default: v = 8'h10;
        endcase
        return v;
    endfunction

    // ========================================================================
    // state
    logic fmt_float_q;
    logic run_q;
    logic [15:0] rts_q;
    logic [15:0] pkt_q;
    logic [1:0] range_q [NCH];
    logic [2:0] notch_q [NCH];
    logic alm_off_q [NCH];
    logic [15:0] data_q [NCH];
    logic [NCH-1:0] under_q;
    logic [NCH-1:0] over_q;
    logic [isc_pkg::INT_W-1:0] int_stat_q;
    logic [isc_pkg::INT_W-1:0] int_mask_q;
    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
    logic tick;
    logic [15:0] rts_cnt_q;
    logic [15:0] pkt_cnt_q;
    isc_pkg::scan_state_t scan_q;

    // ========================================================================
    // bus decode
    logic setup;
    logic wr_en;
    logic [7:0] idx;
    logic in_chcfg;
    logic in_data;
    logic mapped;
    logic [2:0] wr_ch;
    logic [2:0] wr_notch;
    logic [15:0] wr_ms;
    logic [31:0] rd_val;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign idx = (paddr - isc_pkg::REG_CHCFG) >> 2;
    assign in_chcfg = (paddr >= isc_pkg::REG_CHCFG) && (paddr < isc_pkg::REG_DATA)
                      && (idx < 8'(NCH)) && (paddr[1:0] == 2'h0);
    assign in_data = (paddr >= isc_pkg::REG_DATA) && (((paddr - isc_pkg::REG_DATA) >> 2) < 8'(NCH))
                     && (paddr[1:0] == 2'h0);
    assign wr_ch = in_chcfg ? idx[2:0] : 3'((paddr - isc_pkg::REG_DATA) >> 2);
    assign wr_notch = pwdata[isc_pkg::CH_NOTCH_LSB +: 3];
    assign wr_ms = pwdata[15:0];

    // ========================================================================
    // module minimum period, given the format and an optional candidate notch
    logic [15:0] min_now;
    logic [15:0] min_float;
    logic [15:0] min_cand;

    always_comb begin
        min_now = 16'h0000;
        min_float = 16'h0000;
        min_cand = 16'h0000;
        for (int i = 0; i < NCH; i++) begin
            // slowest notch dominates, not the fastest channel
            if (min_rts_ms(notch_q[i], fmt_float_q) > min_now) begin
                min_now = min_rts_ms(notch_q[i], fmt_float_q);
            end
            if (min_rts_ms(notch_q[i], 1'b1) > min_float) begin
                min_float = min_rts_ms(notch_q[i], 1'b1);
            end
            if (i != int'(wr_ch) && min_rts_ms(notch_q[i], fmt_float_q) > min_cand) begin
                min_cand = min_rts_ms(notch_q[i], fmt_float_q);
            end
        end
        if (min_rts_ms(wr_notch, fmt_float_q) > min_cand) begin
            min_cand = min_rts_ms(wr_notch, fmt_float_q);
        end
    end

    // write acceptance checks; a refused write leaves the register unchanged
    logic ok_ctrl;
    logic ok_rts;
    logic ok_chcfg;
    logic reject;

    always_comb begin
        ok_ctrl = 1'b1;
        // format only changes while stopped, and float cannot run a short period
        if (pwdata[isc_pkg::CTRL_FLOAT] != fmt_float_q) begin
            ok_ctrl = !run_q && !(pwdata[isc_pkg::CTRL_FLOAT] && rts_q < min_float);
        end
        ok_rts = (wr_ms >= min_now) && (fmt_float_q ? wr_ms >= isc_pkg::INT_ONLY_LIMIT_MS : 1'b1);
        ok_chcfg = (wr_notch <= isc_pkg::NOTCH_1000) && (rts_q >= min_cand);
        reject = 1'b0;
        if (wr_en) begin
            case (paddr)
                isc_pkg::REG_CTRL: reject = !ok_ctrl;
                isc_pkg::REG_RTS: reject = !ok_rts;
                default: reject = in_chcfg && !ok_chcfg;
            endcase
        end
    end

    // ========================================================================
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_float_q <= 1'b0;
            run_q <= 1'b0;
            rts_q <= isc_pkg::RTS_RESET_MS;
            pkt_q <= isc_pkg::PKT_RESET_MS;
        end else if (wr_en && !reject) begin
            if (paddr == isc_pkg::REG_CTRL) begin
                fmt_float_q <= pwdata[isc_pkg::CTRL_FLOAT];
                run_q <= pwdata[isc_pkg::CTRL_RUN];
            end
            if (paddr == isc_pkg::REG_RTS) begin
                rts_q <= wr_ms;
            end
            if (paddr == isc_pkg::REG_PKT) begin
                pkt_q <= wr_ms;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                range_q[i] <= isc_pkg::RANGE_0_20MA;
                notch_q[i] <= isc_pkg::NOTCH_60;
                alm_off_q[i] <= 1'b0;
            end
        end else if (wr_en && !reject && in_chcfg) begin
            // the current-only variant keeps every channel on 0-20 mA
            if (!CURRENT_ONLY) begin
                range_q[wr_ch] <= pwdata[isc_pkg::CH_RANGE_LSB +: 2];
            end else begin
                range_q[wr_ch] <= isc_pkg::RANGE_0_20MA;
            end
            notch_q[wr_ch] <= wr_notch;
            alm_off_q[wr_ch] <= pwdata[isc_pkg::CH_ALM_OFF];
        end
    end

    // ========================================================================
    // millisecond tick and period timers
    assign tick = (tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
        end else if (tick || !run_q) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    logic rts_due;
    logic pkt_due;
    assign rts_due = run_q && tick && (rts_cnt_q + 16'h0001 >= rts_q);
    assign pkt_due = run_q && tick && (pkt_q != 16'h0000) && (pkt_cnt_q + 16'h0001 >= pkt_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_cnt_q <= 16'h0000;
        end else if (!run_q || rts_due) begin
            rts_cnt_q <= 16'h0000;
        end else if (tick) begin
            rts_cnt_q <= rts_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_cnt_q <= 16'h0000;
        end else if (!run_q || pkt_due) begin
            pkt_cnt_q <= 16'h0000;
        end else if (tick) begin
            pkt_cnt_q <= pkt_cnt_q + 16'h0001;
        end
    end

    // ========================================================================
    // scan and multicast sequencing
    logic [NCH-1:0] under_new;
    logic [NCH-1:0] over_new;

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        channel_range_check u_chk (
            .sample(adc_sample[g*16 +: 16]),
            .range_sel(range_q[g]),
            .alarms_off(alm_off_q[g]),
            .under(under_new[g]),
            .over(over_new[g])
        );
    end

    logic scan_done;
    assign scan_done = (scan_q == isc_pkg::SCAN_WAIT) && adc_valid;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_q <= isc_pkg::SCAN_IDLE;
            scan_req <= 1'b0;
        end else begin
            scan_req <= 1'b0;
            case (scan_q)
                isc_pkg::SCAN_IDLE: begin
                    if (rts_due) begin
                        scan_q <= isc_pkg::SCAN_WAIT;
                        scan_req <= 1'b1;
                    end
                end
                isc_pkg::SCAN_WAIT: begin
                    if (adc_valid) begin
                        scan_q <= isc_pkg::SCAN_SEND;
                    end
                end
                isc_pkg::SCAN_SEND: scan_q <= isc_pkg::SCAN_IDLE;
                default: scan_q <= isc_pkg::SCAN_IDLE;
            endcase
        end
    end

    // fresh samples and flags land together; flags follow each scan both ways
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                data_q[i] <= 16'h0000;
            end
            under_q <= '0;
            over_q <= '0;
        end else if (scan_done) begin
            for (int i = 0; i < NCH; i++) begin
                data_q[i] <= adc_sample[i*16 +: 16];
            end
            under_q <= under_new;
            over_q <= over_new;
        end else begin
            // turning alarms off clears flags at once, not at the next scan
            for (int i = 0; i < NCH; i++) begin
                if (alm_off_q[i]) begin
                    under_q[i] <= 1'b0;
                    over_q[i] <= 1'b0;
                end
            end
        end
    end

    // a packet-interval send only repeats held data, never starts a scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcast_valid <= 1'b0;
            mcast_fresh <= 1'b0;
            mcast_data <= '0;
            ch_fault <= '0;
        end else begin
            mcast_valid <= 1'b0;
            mcast_fresh <= 1'b0;
            ch_fault <= under_q | over_q;
            if (scan_q == isc_pkg::SCAN_SEND) begin
                mcast_valid <= 1'b1;
                mcast_fresh <= 1'b1;
                for (int i = 0; i < NCH; i++) begin
                    mcast_data[i*16 +: 16] <= data_q[i];
                end
            end else if (pkt_due) begin
                mcast_valid <= 1'b1;
                for (int i = 0; i < NCH; i++) begin
                    mcast_data[i*16 +: 16] <= data_q[i];
                end
            end
        end
    end

    // ========================================================================
    // interrupt status, set wins over write-one-to-clear
    logic [isc_pkg::INT_W-1:0] int_set;
    logic [isc_pkg::INT_W-1:0] int_clr;

    always_comb begin
        int_set = '0;
        int_set[isc_pkg::INT_SCAN] = (scan_q == isc_pkg::SCAN_SEND);
        int_set[isc_pkg::INT_PKT] = pkt_due && (scan_q != isc_pkg::SCAN_SEND);
        int_set[isc_pkg::INT_FAULT] = scan_done && |((under_new | over_new) & ~(under_q | over_q));
        int_set[isc_pkg::INT_REJECT] = reject;
        int_clr = (wr_en && paddr == isc_pkg::REG_INT_STAT) ? pwdata[isc_pkg::INT_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
            if (wr_en && paddr == isc_pkg::REG_INT_MASK) begin
                int_mask_q <= pwdata[isc_pkg::INT_W-1:0];
            end
            irq <= |(((int_stat_q & ~int_clr) | int_set) & int_mask_q);
        end
    end

    // ========================================================================
    // read mux and apb answer
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            isc_pkg::REG_CTRL: begin
                rd_val[isc_pkg::CTRL_FLOAT] = fmt_float_q;
                rd_val[isc_pkg::CTRL_RUN] = run_q;
            end
            isc_pkg::REG_RTS: rd_val[15:0] = rts_q;
            isc_pkg::REG_PKT: rd_val[15:0] = pkt_q;
            isc_pkg::REG_MINRTS: rd_val[15:0] = min_now;
            isc_pkg::REG_FLAGS: begin
                rd_val[NCH-1:0] = under_q;
                rd_val[isc_pkg::FLAGS_OVER_LSB +: NCH] = over_q;
                rd_val[isc_pkg::FLAGS_FAULT_LSB +: NCH] = under_q | over_q;
            end
            isc_pkg::REG_INT_STAT: rd_val[isc_pkg::INT_W-1:0] = int_stat_q;
            isc_pkg::REG_INT_MASK: rd_val[isc_pkg::INT_W-1:0] = int_mask_q;
            // bits: range, notch, sampling, filter, process, rate, scaling
            isc_pkg::REG_FEATURES: rd_val[6:0] = {{4{fmt_float_q}}, 2'b11, !CURRENT_ONLY};
            default: begin
                if (in_chcfg) begin
                    rd_val[isc_pkg::CH_RANGE_LSB +: 2] = range_q[wr_ch];
                    rd_val[isc_pkg::CH_NOTCH_LSB +: 3] = notch_q[wr_ch];
                    rd_val[isc_pkg::CH_ALM_OFF] = alm_off_q[wr_ch];
                    rd_val[isc_pkg::CH_RES_LSB +: 8] = resolution(notch_q[wr_ch]);
                    rd_val[isc_pkg::CH_SETTLE_LSB +: 16] = 16'(step_ms(notch_q[wr_ch]) + rts_q);
                end else if (in_data) begin
                    rd_val[15:0] = data_q[wr_ch];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // one wait-free access cycle: answer is prepared during setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end
endmodule

// File: core/isc_pkg.sv
// constants, encodings and register map of the isolated input sample control
// ============================================================================
package isc_pkg;

    // ========================================================================
    // sizes and timing
    localparam int NCH = 6;
    localparam int DATA_W = 16;
    localparam int MS_W = 16;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
    localparam logic [15:0] INT_ONLY_LIMIT_MS = 16'h0019;

    // ========================================================================
    // encodings
    localparam logic [1:0] RANGE_BIP10 = 2'h0;
    localparam logic [1:0] RANGE_0_5V = 2'h1;
    localparam logic [1:0] RANGE_0_10V = 2'h2;
    localparam logic [1:0] RANGE_0_20MA = 2'h3;
    localparam logic [2:0] NOTCH_10 = 3'h0;
    localparam logic [2:0] NOTCH_50 = 3'h1;
    localparam logic [2:0] NOTCH_60 = 3'h2;
    localparam logic [2:0] NOTCH_100 = 3'h3;
    localparam logic [2:0] NOTCH_250 = 3'h4;
    localparam logic [2:0] NOTCH_1000 = 3'h5;

    // limits as signed converter codes: full code span equals the limit signal
    localparam logic signed [15:0] CODE_MAX = 16'sh7FFF;
    localparam logic signed [15:0] CODE_MIN_BIP = 16'sh8000;
    localparam logic signed [15:0] CODE_MIN_UNI = 16'sh0000;

    // ========================================================================
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_RTS = 8'h04;
    localparam logic [7:0] REG_PKT = 8'h08;
    localparam logic [7:0] REG_MINRTS = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    localparam logic [7:0] REG_INT_STAT = 8'h14;
    localparam logic [7:0] REG_INT_MASK = 8'h18;
    localparam logic [7:0] REG_FEATURES = 8'h1C;
    localparam logic [7:0] REG_CHCFG = 8'h20;
    localparam logic [7:0] REG_DATA = 8'h40;

    // field positions
    localparam int CTRL_FLOAT = 0;
    localparam int CTRL_RUN = 1;
    localparam int CH_RANGE_LSB = 0;
    localparam int CH_NOTCH_LSB = 2;
    localparam int CH_ALM_OFF = 5;
    localparam int CH_RES_LSB = 8;
    localparam int CH_SETTLE_LSB = 16;
    localparam int FLAGS_OVER_LSB = 8;
    localparam int FLAGS_FAULT_LSB = 16;
    localparam int INT_SCAN = 0;
    localparam int INT_PKT = 1;
    localparam int INT_FAULT = 2;
    localparam int INT_REJECT = 3;
    localparam int INT_W = 4;

    // reset values
    localparam logic [15:0] RTS_RESET_MS = 16'h0066;
    localparam logic [15:0] PKT_RESET_MS = 16'h0000;

    typedef enum logic [1:0] {SCAN_IDLE, SCAN_WAIT, SCAN_SEND} scan_state_t;

endpackage

// File: core/channel_range_check.sv
// under/overrange comparison of one channel sample
`timescale 1ns/1ns
module channel_range_check (
    // sample and channel setup
    input wire logic signed [15:0] sample,
    input wire logic [1:0] range_sel,
    input wire logic alarms_off,
    // result
    output logic under,
    output logic over
);
    logic signed [15:0] lo;

    always_comb begin
        // bipolar voltage is the only range with a negative floor
        if (range_sel == isc_pkg::RANGE_BIP10) begin
            lo = isc_pkg::CODE_MIN_BIP;
        end else begin
            lo = isc_pkg::CODE_MIN_UNI;
        end
    end

    always_comb begin
        under = 1'b0;
        over = 1'b0;
        if (!alarms_off) begin
            under = (sample <= lo);
            over = (sample >= isc_pkg::CODE_MAX);
        end
    end
endmodule

// File: dv/sample_control_props.sv
// assertion checker for the sample control ports
`timescale 1ns/1ns
module sample_control_props #(
    parameter int NCH = 6
) (
    // clock, reset and apb
    input wire logic pclk, input wire logic presetn, input wire logic psel, input wire logic penable,
    input wire logic pwrite, input wire logic [7:0] paddr, input wire logic [31:0] pwdata,
    input wire logic pready, input wire logic pslverr,
    // converter, multicast, status
    input wire logic scan_req, input wire logic adc_valid, input wire logic mcast_valid,
    input wire logic mcast_fresh, input wire logic [NCH-1:0] ch_fault, input wire logic irq
);
    // ========================================================================
    // properties
    wire apb_wr = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_one; psel && !penable |=> pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("no pready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_scan_pulse; scan_req |=> !scan_req; endproperty
    a_scan_pulse: assert property (p_scan_pulse) else $error("scan_req longer than a cycle");
    property p_fresh_valid; mcast_fresh |-> mcast_valid; endproperty
    a_fresh_valid: assert property (p_fresh_valid) else $error("fresh without multicast");
    property p_fresh_cause; mcast_fresh |-> $past(adc_valid, 2); endproperty
    a_fresh_cause: assert property (p_fresh_cause) else $error("fresh multicast without scan");
    // a sample shows two edges on, an alarms-off write three
    property p_fault_cause; !$stable(ch_fault) |-> $past(adc_valid, 2) || $past(apb_wr, 3); endproperty
    a_fault_cause: assert property (p_fault_cause) else $error("ch_fault moved without cause");
    property p_irq_mask; apb_wr && pready && paddr == isc_pkg::REG_INT_MASK && pwdata == 32'h0 |=> ##1 !irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq high with mask cleared");
    c_fresh: cover property (mcast_valid && mcast_fresh);
    c_repeat: cover property (mcast_valid && !mcast_fresh);
    c_err: cover property (pslverr);
endmodule
bind sample_control sample_control_props #(.NCH(NCH)) sample_control_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .scan_req(scan_req), .adc_valid(adc_valid), .mcast_valid(mcast_valid),
    .mcast_fresh(mcast_fresh), .ch_fault(ch_fault), .irq(irq));

// File: dv/adc_model.sv
// converter model answering scan requests after a set latency
`timescale 1ns/1ns
module adc_model #(
    parameter int NCH = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request, latency and analog levels
    input wire logic scan_req,
    input wire logic [3:0] lat,
    input wire logic [NCH*16-1:0] level,
    // answer
    output logic adc_valid,
    output logic [NCH*16-1:0] adc_sample
);
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            adc_valid <= 1'b0;
            adc_sample <= '0;
        end else begin
            adc_valid <= 1'b0;
            // bus toggles while idle so stale data never passes for a sample
            adc_sample <= ~adc_sample;
            if (scan_req) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
                if (cnt <= 4'h1) begin
                    busy <= 1'b0;
                    adc_valid <= 1'b1;
                    adc_sample <= level;
                end
            end
        end
    end
endmodule

// File: dv/tb_top.sv
// self-checking testbench of the sample control
`timescale 1ns/1ns
module tb_top;
    // ========================================================================
    // signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, scan_req, adc_valid, mcast_valid, mcast_fresh, irq;
    logic [95:0] adc_sample, mcast_data, level = 96'h0;
    logic [5:0] ch_fault;
    logic [3:0] lat = 4'h1;
    int err_count = 0;
    int num_checks = 0;
    int t_min[6] = '{102, 22, 19, 12, 10, 10};
    int t_stp[6] = '{400, 80, 68, 40, 16, 4};
    int t_res[6] = '{16, 16, 16, 16, 15, 10};
    always #50 pclk = ~pclk;
    sample_control #(.TICK_CYCLES(10)) sample_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_req(scan_req), .adc_valid(adc_valid), .adc_sample(adc_sample),
        .mcast_valid(mcast_valid), .mcast_fresh(mcast_fresh), .mcast_data(mcast_data), .ch_fault(ch_fault), .irq(irq));
    adc_model adc_model_inst (.pclk(pclk), .presetn(presetn), .scan_req(scan_req), .lat(lat), .level(level),
        .adc_valid(adc_valid), .adc_sample(adc_sample));
    // ========================================================================
    // tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rdat);
    endtask
    task automatic wait_mc(input logic f);
        int i;
        for (i = 0; i < 3000 && !(mcast_valid === 1'b1 && mcast_fresh === f); i++) @(posedge pclk);
        chk("multicast", 32'h1, 32'(i < 3000));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========================================================================
    // tests
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(isc_pkg::REG_CHCFG, 32'h00AA100B, "chcfg reset");
        rd(isc_pkg::REG_FEATURES, 32'h00000007, "features int");
        rd(isc_pkg::REG_MINRTS, 32'h00000013, "minrts reset");
        for (int n = 0; n < 6; n++) begin
            apb(1'b1, isc_pkg::REG_CHCFG, 32'(3 + 4 * n));
            rd(isc_pkg::REG_CHCFG, {16'(t_stp[n] + 102), 8'(t_res[n]), 8'(3 + 4 * n)}, "chcfg notch");
            rd(isc_pkg::REG_MINRTS, 32'((t_min[n] > 19) ? t_min[n] : 19), "minrts");
        end
        apb(1'b1, isc_pkg::REG_CHCFG, 32'h0000001B);
        rd(isc_pkg::REG_CHCFG, 32'h006A0A17, "notch 6 kept");
        rd(isc_pkg::REG_INT_STAT, 32'h00000008, "reject");
        apb(1'b1, isc_pkg::REG_INT_STAT, 32'h0000000F);
        $display("notch test done");
        apb(1'b1, isc_pkg::REG_CTRL, 32'h00000001);
        rd(isc_pkg::REG_FEATURES, 32'h0000007F, "features float");
        rd(isc_pkg::REG_MINRTS, 32'h00000019, "minrts float");
        apb(1'b1, isc_pkg::REG_RTS, 32'h00000014);
        rd(isc_pkg::REG_RTS, 32'h00000066, "rts float");
        apb(1'b1, isc_pkg::REG_CTRL, 32'h00000000);
        apb(1'b1, isc_pkg::REG_RTS, 32'h00000014);
        rd(isc_pkg::REG_RTS, 32'h00000014, "rts int");
        apb(1'b1, isc_pkg::REG_CHCFG + 8'h04, 32'h00000009);
        rd(isc_pkg::REG_CHCFG + 8'h04, 32'h00581009, "range 0-5V");
        apb(1'b1, isc_pkg::REG_CHCFG + 8'h08, 32'h00000008);
        $display("format test done");
        // ch2 bipolar at zero is legal, ch1 unipolar at zero is not
        level <= 96'h0200_0100_8000_0000_0000_7FFF;
        apb(1'b1, isc_pkg::REG_INT_MASK, 32'h00000001);
        apb(1'b1, isc_pkg::REG_CTRL, 32'h00000002);
        wait_mc(1'b1);
        chk("scan data", 32'h1, 32'(mcast_data === level));
        repeat (4) @(posedge pclk);
        chk("ch_fault", 32'h0000000B, 32'(ch_fault));
        chk("irq set", 32'h1, 32'(irq));
        rd(isc_pkg::REG_FLAGS, 32'h000B010A, "flags");
        apb(1'b1, isc_pkg::REG_INT_STAT, 32'h0000000F);
        repeat (2) @(posedge pclk);
        chk("irq clear", 32'h0, 32'(irq));
        apb(1'b1, isc_pkg::REG_CHCFG, 32'h00000037);
        rd(isc_pkg::REG_FLAGS, 32'h000A000A, "alarms off");
        lat <= 4'h9;
        level <= {6{16'h1000}};
        wait_mc(1'b1);
        repeat (4) @(posedge pclk);
        rd(isc_pkg::REG_FLAGS, 32'h00000000, "flags clear");
        chk("fault clear", 32'h0, 32'(ch_fault));
        $display("scan test done");
        apb(1'b1, isc_pkg::REG_PKT, 32'h00000005);
        wait_mc(1'b0);
        chk("held data", 32'h1, 32'(mcast_data === {6{16'h1000}}));
        apb(1'b1, isc_pkg::REG_INT_MASK, 32'h00000000);
        apb(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'h1, 32'(rerr));
        chk("unmapped", 32'h0, rdat);
        $display("packet test done");
        tally_and_finish();
    end
    initial begin
        #(20000 * 100);
        err_count++;
        tally_and_finish();
    end
endmodule
